// *** hw/adc_notch_and_level_control.v ***
// Notes on behaviour
// [RULE_01] The notch filter runs only while the enable bit, bit 7 of register 0x1B, is one.
// [RULE_02] Each coefficient is 14 bits built from a high seven-bit and a low seven-bit part.
// [RULE_03] Coefficients are written and used as signed two's complement numbers.
// [RULE_04] All four coefficient registers carry an update bit in bit 8, all with equal effect.
// [RULE_05] Pulsing any update bit low-high-low moves all four parts into the filter together.
// [RULE_06] While any update bit stays high the active coefficients track the registers.
// [RULE_07] Level control off means manual gain drives the amplifier, on means the loop does.
// [RULE_08] The ceiling field limits gain from -6.75 dB at 000 to +35.25 dB at 111 in 6 dB steps.
// [RULE_09] The floor field holds gain at least -12 dB at 000 up to +30 dB at 111 in 6 dB steps.
// [RULE_10] The hold field delays gain increases: 0, 2 ms doubling per code, 1 s from 1010 up.
// [RULE_11] The target field sets the level from -28.5 dBFS in 1.5 dB steps up to -6 dBFS.
// [RULE_12] Software should not combine zero-cross detect with level control or limiter.
// [RULE_13] With level control on the applied gain stays between floor and ceiling.
`timescale 1ns/10ps
`default_nettype none
`include "adc_notch_level_map.vh"

module adc_notch_and_level_control #(
  parameter HOLD_BASE_CYC = `HOLD_BASE_NS / `CLK_PERIOD_NS
) (
  input  wire               clk_i,
  input  wire               resetn_i,
  input  wire        [6:0]  reg_addr_i,
  input  wire        [8:0]  reg_wdata_i,
  input  wire               reg_wr_i,
  output reg         [8:0]  reg_rdata_o,
  input  wire        [5:0]  manual_amp_gain_i,
  input  wire               sample_tick_i,
  input  wire        [5:0]  level_att_i,
  input  wire               zero_cross_i,
  output reg                notch_enable_o,
  output reg  signed [13:0] notch_coef_a0_o,
  output reg  signed [13:0] notch_coef_a1_o,
  output reg         [5:0]  amp_gain_o
);

  reg  [8:0]  coef0_high_r;
  reg  [8:0]  coef0_low_r;
  reg  [8:0]  coef1_high_r;
  reg  [8:0]  coef1_low_r;
  reg  [8:0]  gain_limits_r;
  reg  [8:0]  hold_target_r;
  reg  [5:0]  loop_gain_r;
  reg  [5:0]  loop_gain_nxt;
  reg  [17:0] base_cnt_r;
  reg  [9:0]  hold_cnt_r;
  reg  [8:0]  rdata_nxt;

  wire        level_ctrl_enable;
  wire        zero_cross_detect_enable;
  wire [2:0]  level_gain_ceiling;
  wire [2:0]  level_gain_floor;
  wire [3:0]  level_hold_time;
  wire [3:0]  level_target;
  wire        coef_update_strobe;
  wire [5:0]  ceil_code;
  wire [5:0]  floor_code;
  wire [5:0]  target_att;
  reg  [9:0]  hold_units;
  wire        hold_done;
  wire        base_tick;
  wire        too_loud;
  wire        too_quiet;
  wire        may_change;
  wire [5:0]  clamped_gain;

  assign level_ctrl_enable        = gain_limits_r[`BIT_LEVEL_ENABLE];
  assign level_gain_ceiling       = gain_limits_r[`FLD_CEILING];
  assign level_gain_floor         = gain_limits_r[`FLD_FLOOR];
  assign zero_cross_detect_enable = hold_target_r[`BIT_ZERO_CROSS];
  assign level_hold_time          = hold_target_r[`FLD_HOLD];
  assign level_target             = hold_target_r[`FLD_TARGET];

  // [RULE_04] any update bit
  assign coef_update_strobe = coef0_high_r[`BIT_UPDATE] | coef0_low_r[`BIT_UPDATE] |
                              coef1_high_r[`BIT_UPDATE] | coef1_low_r[`BIT_UPDATE];

  // [RULE_08] ceiling code
  assign ceil_code  = `GAIN_CEIL_BASE + {level_gain_ceiling, 3'h0};
  // [RULE_09] floor code
  assign floor_code = {level_gain_floor, 3'h0};
  // [RULE_11] target attenuation
  assign target_att = `TARGET_ATT_BASE - {1'b0, level_target, 1'b0};

  // [RULE_10] hold length
  always @* begin
    case (level_hold_time)
      `HOLD_CODE_ZERO: hold_units = 10'h000;
      4'h1:            hold_units = 10'h001;
      4'h2:            hold_units = 10'h002;
      4'h3:            hold_units = 10'h004;
      4'h4:            hold_units = 10'h008;
      4'h5:            hold_units = 10'h010;
      4'h6:            hold_units = 10'h020;
      4'h7:            hold_units = 10'h040;
      4'h8:            hold_units = 10'h080;
      4'h9:            hold_units = 10'h100;
      default:         hold_units = `HOLD_MAX_UNITS;
    endcase
  end

  // Hold timer status
  assign hold_done  = (hold_cnt_r >= hold_units);
  assign base_tick  = (base_cnt_r == HOLD_BASE_CYC - 1);

  // Level compare
  assign too_loud   = (level_att_i < target_att);
  assign too_quiet  = (level_att_i > target_att);
  assign may_change = sample_tick_i & (~zero_cross_detect_enable | zero_cross_i);

  // [RULE_13] clamp to limits
  assign clamped_gain = (loop_gain_r > ceil_code) ? ceil_code :
                        (loop_gain_r < floor_code) ? floor_code : loop_gain_r;

  // Next loop gain
  always @* begin
    loop_gain_nxt = clamped_gain;
    if (may_change) begin
      if (too_loud && clamped_gain > floor_code) begin
        loop_gain_nxt = clamped_gain - 6'h01;
      end else if (too_quiet && hold_done && clamped_gain < ceil_code) begin
        loop_gain_nxt = clamped_gain + 6'h01;
      end
    end
  end

  // Read data select
  always @* begin
    case (reg_addr_i)
      `ADDR_NOTCH_CTRL_COEF0_HIGH: rdata_nxt = coef0_high_r;
      `ADDR_NOTCH_COEF0_LOW:       rdata_nxt = {coef0_low_r[8], 1'b0, coef0_low_r[6:0]};
      `ADDR_NOTCH_COEF1_HIGH:      rdata_nxt = {coef1_high_r[8], 1'b0, coef1_high_r[6:0]};
      `ADDR_NOTCH_COEF1_LOW:       rdata_nxt = {coef1_low_r[8], 1'b0, coef1_low_r[6:0]};
      `ADDR_LEVEL_GAIN_LIMITS:     rdata_nxt = {gain_limits_r[8], 2'h0, gain_limits_r[5:0]};
      `ADDR_LEVEL_HOLD_TARGET:     rdata_nxt = hold_target_r;
      default:                     rdata_nxt = 9'h000;
    endcase
  end

  // Register writes
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      coef0_high_r  <= `RST_NOTCH;
      coef0_low_r   <= `RST_NOTCH;
      coef1_high_r  <= `RST_NOTCH;
      coef1_low_r   <= `RST_NOTCH;
      gain_limits_r <= `RST_LEVEL_GAIN_LIMITS;
      hold_target_r <= `RST_LEVEL_HOLD_TARGET;
      reg_rdata_o   <= 9'h000;
    end else begin
      reg_rdata_o <= rdata_nxt;
      if (reg_wr_i) begin
        case (reg_addr_i)
          `ADDR_NOTCH_CTRL_COEF0_HIGH: coef0_high_r  <= reg_wdata_i;
          `ADDR_NOTCH_COEF0_LOW:       coef0_low_r   <= reg_wdata_i;
          `ADDR_NOTCH_COEF1_HIGH:      coef1_high_r  <= reg_wdata_i;
          `ADDR_NOTCH_COEF1_LOW:       coef1_low_r   <= reg_wdata_i;
          `ADDR_LEVEL_GAIN_LIMITS:     gain_limits_r <= reg_wdata_i;
          `ADDR_LEVEL_HOLD_TARGET:     hold_target_r <= reg_wdata_i;
          default: begin
          end
        endcase
      end
    end
  end

  // Notch outputs
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      notch_enable_o  <= 1'b0;
      notch_coef_a0_o <= 14'h0000;
      notch_coef_a1_o <= 14'h0000;
    end else begin
      // [RULE_01] enable follows bit
      notch_enable_o <= coef0_high_r[`BIT_NOTCH_ENABLE];
      // [RULE_05] atomic coefficient transfer
      // [RULE_06] continuous while high
      if (coef_update_strobe) begin
        // [RULE_02] join halves
        // [RULE_03] signed coefficients
        notch_coef_a0_o <= {coef0_high_r[`FLD_COEF_PART], coef0_low_r[`FLD_COEF_PART]};
        notch_coef_a1_o <= {coef1_high_r[`FLD_COEF_PART], coef1_low_r[`FLD_COEF_PART]};
      end
    end
  end

  // Level loop and hold timer
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      loop_gain_r <= 6'h00;
      base_cnt_r  <= 18'h00000;
      hold_cnt_r  <= 10'h000;
      amp_gain_o  <= 6'h00;
    end else begin
      if (base_tick) begin
        base_cnt_r <= 18'h00000;
      end else begin
        base_cnt_r <= base_cnt_r + 18'h00001;
      end
      // [RULE_10] hold restarts on loud
      if (!level_ctrl_enable || (sample_tick_i && too_loud)) begin
        hold_cnt_r <= 10'h000;
      end else if (base_tick && !hold_done) begin
        hold_cnt_r <= hold_cnt_r + 10'h001;
      end
      if (level_ctrl_enable) begin
        loop_gain_r <= loop_gain_nxt;
      end else begin
        loop_gain_r <= manual_amp_gain_i;
      end
      // [RULE_07] gain source select
      if (level_ctrl_enable) begin
        amp_gain_o <= loop_gain_nxt;
      end else begin
        amp_gain_o <= manual_amp_gain_i;
      end
    end
  end

endmodule // adc_notch_and_level_control
`default_nettype wire

// *** hw/adc_notch_level_map.vh ***
`ifndef ADC_NOTCH_LEVEL_MAP_VH
`define ADC_NOTCH_LEVEL_MAP_VH

// Register addresses
`define ADDR_NOTCH_CTRL_COEF0_HIGH 7'h1B
`define ADDR_NOTCH_COEF0_LOW       7'h1C
`define ADDR_NOTCH_COEF1_HIGH      7'h1D
`define ADDR_NOTCH_COEF1_LOW       7'h1E
`define ADDR_LEVEL_GAIN_LIMITS     7'h20
`define ADDR_LEVEL_HOLD_TARGET     7'h21

// Reset values
`define RST_NOTCH                  9'h000
`define RST_LEVEL_GAIN_LIMITS      9'h038
`define RST_LEVEL_HOLD_TARGET      9'h00B

// Field positions
`define BIT_UPDATE                 8
`define BIT_NOTCH_ENABLE           7
`define BIT_LEVEL_ENABLE           8
`define BIT_ZERO_CROSS             8
`define FLD_COEF_PART              6:0
`define FLD_CEILING                5:3
`define FLD_FLOOR                  2:0
`define FLD_HOLD                   7:4
`define FLD_TARGET                 3:0

// Gain codes in 0.75 dB steps, code 0 = -12 dB
`define GAIN_CEIL_BASE             6'h07
`define GAIN_STEP_6DB_SHIFT        3
// Target in 0.75 dB attenuation units, code 0 = -28.5 dBFS
`define TARGET_ATT_BASE            6'h26
`define TARGET_STEP_SHIFT          1

// Hold timing
`define HOLD_BASE_NS               2000000
`define CLK_PERIOD_NS              8
`define HOLD_MAX_CODE              4'hA
`define HOLD_MAX_UNITS             10'h1F4
`define HOLD_CODE_ZERO             4'h0

`endif

// *** tb/adc_level_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_level_chk #(
  parameter HOLD_BASE_CYC = 4
) (
  input wire logic               clk_i,
  input wire logic               resetn_i,
  input wire logic        [6:0]  reg_addr_i,
  input wire logic        [8:0]  reg_wdata_i,
  input wire logic               reg_wr_i,
  input wire logic        [8:0]  reg_rdata_o,
  input wire logic        [5:0]  manual_amp_gain_i,
  input wire logic               sample_tick_i,
  input wire logic        [5:0]  level_att_i,
  input wire logic               zero_cross_i,
  input wire logic               notch_enable_o,
  input wire logic signed [13:0] notch_coef_a0_o,
  input wire logic signed [13:0] notch_coef_a1_o,
  input wire logic        [5:0]  amp_gain_o
);
  logic [8:0] sh [0:6];
  wire        on  = sh[5][8];
  wire        nen = sh[0][7];
  wire [3:0]  upd = {sh[0][8], sh[1][8], sh[2][8], sh[3][8]};
  wire [13:0] c0  = {sh[0][6:0], sh[1][6:0]};
  wire [13:0] c1  = {sh[2][6:0], sh[3][6:0]};
  wire [5:0]  flo = {sh[5][2:0], 3'h0};
  wire [5:0]  cei = {sh[5][5:3], 3'h7};
  wire [5:0]  tgt = 6'h26 - {1'h0, sh[6][3:0], 1'h0};
  wire        hit = reg_addr_i >= 7'h1B && reg_addr_i <= 7'h21 && reg_addr_i != 7'h1F;
  wire [8:0]  msk = (reg_addr_i == 7'h20) ? 9'h13F :
                    (reg_addr_i == 7'h1B || reg_addr_i == 7'h21) ? 9'h1FF : 9'h17F;
  wire [8:0]  rdx = hit ? (sh[reg_addr_i - 7'h1B] & msk) : 9'h000;
  wire        stp = on && (zero_cross_i || !sh[6][8]) && sample_tick_i;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 7; i++) sh[i] <= (i == 5) ? 9'h038 : (i == 6) ? 9'h00B : 9'h000;
    end else if (reg_wr_i && hit) begin
      sh[reg_addr_i - 7'h1B] <= reg_wdata_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  read_back_a: assert property (reg_rdata_o == $past(rdx))
    else $error("bad read data");
  coef_hold_a: assert property (upd == 4'h0 |=> $stable(notch_coef_a0_o) && $stable(notch_coef_a1_o))
    else $error("coefficients moved");
  coef_copy_a: assert property (upd != 4'h0 |=> notch_coef_a0_o == $past(c0) && notch_coef_a1_o == $past(c1))
    else $error("coefficients not copied");
  notch_on_a: assert property (notch_enable_o == $past(nen))
    else $error("bad notch enable");
  manual_gain_a: assert property (!on |=> amp_gain_o == $past(manual_amp_gain_i))
    else $error("gain not manual");
  gain_limits_a: assert property (on && $past(on) |=> amp_gain_o >= flo && amp_gain_o <= cei)
    else $error("gain out of limits");
  step_down_a: assert property (stp && $past(on) && level_att_i < tgt && amp_gain_o > flo
    |=> amp_gain_o == $past(amp_gain_o) - 6'h01) else $error("no step down");
  step_up_a: assert property (stp && $past(on) && level_att_i > tgt && amp_gain_o < cei
    && sh[6][7:4] == 4'h0 |=> amp_gain_o == $past(amp_gain_o) + 6'h01) else $error("no step up");
endmodule // adc_level_chk
bind adc_notch_and_level_control adc_level_chk #(.HOLD_BASE_CYC(HOLD_BASE_CYC)) i_level_chk (.*);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic              clk_i = 0, resetn_i = 0, reg_wr_i = 0, sample_tick_i = 0, zero_cross_i = 0;
  logic        [6:0] reg_addr_i = 7'h00;
  logic        [8:0] reg_wdata_i = 9'h000;
  logic        [5:0] manual_amp_gain_i = 6'h03, level_att_i = 6'h00;
  wire         [8:0] reg_rdata_o;
  wire               notch_enable_o;
  wire signed [13:0] notch_coef_a0_o, notch_coef_a1_o;
  wire         [5:0] amp_gain_o;
  int                n_fail = 0, checked = 0;
  logic       [24:0] rows [7] = '{{7'h1B, 9'h0A5, 9'h0A5}, {7'h1C, 9'h0FF, 9'h07F},
    {7'h1D, 9'h0C3, 9'h043}, {7'h1E, 9'h055, 9'h055}, {7'h20, 9'h0FF, 9'h03F},
    {7'h21, 9'h0AB, 9'h0AB}, {7'h1F, 9'h1FF, 9'h000}};
  always #4 clk_i = ~clk_i;
  adc_notch_and_level_control #(.HOLD_BASE_CYC(4)) i_adc_notch_and_level_control (.*);
  task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] exp);
    reg_addr_i <= a;
    @(posedge clk_i);
    #1 chk("read", {5'h00, reg_rdata_o}, {5'h00, exp});
    @(posedge clk_i);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      sample_tick_i <= 1'b1;
      @(posedge clk_i);
      sample_tick_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clk_i);
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd(7'h1B, 9'h000);
    rd(7'h20, 9'h038);
    rd(7'h21, 9'h00B);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][24:18], rows[i][17:9]);
      rd(rows[i][24:18], rows[i][8:0]);
    end
    chk("coef_a0", notch_coef_a0_o, 14'h0000);
    wr(7'h1E, 9'h155);
    wr(7'h1E, 9'h055);
    chk("coef_a0", notch_coef_a0_o, 14'h12FF);
    chk("coef_a1", notch_coef_a1_o, 14'h21D5);
    chk("notch_en", {13'h0000, notch_enable_o}, 14'h0001);
    wr(7'h1C, 9'h100);
    wr(7'h1D, 9'h001);
    wr(7'h1C, 9'h000);
    chk("coef_a0", notch_coef_a0_o, 14'h1280);
    chk("coef_a1", notch_coef_a1_o, 14'h00D5);
    wr(7'h21, 9'h00B);
    wr(7'h20, 9'h111);
    level_att_i <= 6'h28;
    ticks(30);
    chk("gain_max", {8'h00, amp_gain_o}, 14'h0017);
    level_att_i <= 6'h05;
    ticks(30);
    chk("gain_min", {8'h00, amp_gain_o}, 14'h0008);
    wr(7'h21, 9'h0FB);
    level_att_i <= 6'h28;
    ticks(500);
    chk("gain_held", {8'h00, amp_gain_o}, 14'h0008);
    ticks(700);
    chk("gain_rise", {8'h00, amp_gain_o}, 14'h0017);
    wr(7'h20, 9'h011);
    ticks(2);
    chk("gain_manual", {8'h00, amp_gain_o}, 14'h0003);
    stop_test;
  end
endmodule // tb
`default_nettype wire
